// ===== core/eeim_pkg.sv
// constants for the energy event interrupt mask block: addresses, field positions,
// event-source vector layout and reset values.
// assumes a 16-bit word address register port with 32-bit data.
package eeim_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int NUM_EVT = 12;

	// register word addresses
	localparam logic [ADDR_W-1:0] EN_LOW_ADDR = 16'hE50A;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'hE50C;
	localparam logic [ADDR_W-1:0] MODE_ADDR = 16'hE50D;

	// reset values
	localparam logic [NUM_EVT-1:0] EN_LOW_RST = 12'h000;
	localparam logic [NUM_EVT-1:0] STATUS_RST = 12'h000;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h00000000;

	// event bit positions, shared by enable and status registers
	localparam int EVT_TOT_ACT_HF = 0;
	localparam int EVT_FUND_ACT_HF = 1;
	localparam int EVT_TOT_REA_HF = 2;
	localparam int EVT_FUND_REA_HF = 3;
	localparam int EVT_APP_HF = 4;
	localparam int EVT_LINE_DONE = 5;
	localparam int EVT_ACT_SIGN_A = 6;
	localparam int EVT_SUM1_SIGN = 9;
	localparam int EVT_REA_SIGN_A = 10;

	// measurement mode register select bits
	localparam int MODE_ACT_SEL_BIT = 0;
	localparam int MODE_REA_SEL_BIT = 1;

	localparam int NUM_PHASE = 3;
	localparam int NUM_REA_PHASE = 2;

	// layout of the vector watched for changes
	localparam int SRC_TOT_ACT = 0;
	localparam int SRC_FUND_ACT = 3;
	localparam int SRC_TOT_REA = 6;
	localparam int SRC_FUND_REA = 9;
	localparam int SRC_APP = 12;
	localparam int SRC_ACT_TOT_SIGN = 15;
	localparam int SRC_ACT_FUND_SIGN = 18;
	localparam int SRC_REA_TOT_SIGN = 21;
	localparam int SRC_REA_FUND_SIGN = 23;
	localparam int SRC_SUM1_SIGN = 25;
	localparam int SRC_W = 26;

endpackage

// ===== core/eeim_change.sv
// change detector: one pulse per bit for each cycle in which that bit differs
// from its value in the previous cycle.
// assumes inputs come from logic on the same clock.
`timescale 1ns/1ns
module eeim_change #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] chg
);

	logic [W-1:0] prev_r;
	logic         primed_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_r <= '0;
		end else begin
			prev_r <= din;
		end
	end

	// the first sample after reset only loads history, so a bit that
	// already sits high does not raise a false event
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			primed_r <= 1'b0;
		end else begin
			primed_r <= 1'b1;
		end
	end

	assign chg = primed_r ? (din ^ prev_r) : '0;

endmodule

// ===== core/eeim_top.sv
// energy event interrupt mask: sticky event status, low enable register,
// sign source selects and one level interrupt output.
// assumes the register port master and all event sources run on clk.
`timescale 1ns/1ns
//
// Function
// [RULE_01] enabled total active accumulator bit 30 toggle, any phase, raises request
// [RULE_02] enabled fundamental active accumulator bit 30 toggle, any phase, raises request
// [RULE_03] enabled total reactive accumulator bit 30 toggle, any phase, raises request
// [RULE_04] enabled fundamental reactive accumulator bit 30 toggle, any phase, raises request
// [RULE_05] enabled apparent accumulator bit 30 toggle, any phase, raises request
// [RULE_06] enabled completion of line-cycle accumulation raises request
// [RULE_07] bits 6..8 enable phase A..C active sign change; mode bit selects source
// [RULE_08] bit 9 enables sign change of first pulse output power sum
// [RULE_09] bits 10..11 enable phase A, B reactive sign change; mode bit selects source
// [RULE_10] status records events unmasked; request only for set status with enable
module eeim_top
	import eeim_pkg::*;
(
	input  wire logic                             clk,
	input  wire logic                             nrst,
	input  wire logic [eeim_pkg::ADDR_W-1:0]      addr,
	input  wire logic [eeim_pkg::DATA_W-1:0]      wdata,
	input  wire logic                             wr_en,
	input  wire logic                             rd_en,
	output logic      [eeim_pkg::DATA_W-1:0]      rdata,
	output logic                                  irq,
	input  wire logic [eeim_pkg::NUM_PHASE-1:0]   tot_act_accum_b30,
	input  wire logic [eeim_pkg::NUM_PHASE-1:0]   fund_act_accum_b30,
	input  wire logic [eeim_pkg::NUM_PHASE-1:0]   tot_rea_accum_b30,
	input  wire logic [eeim_pkg::NUM_PHASE-1:0]   fund_rea_accum_b30,
	input  wire logic [eeim_pkg::NUM_PHASE-1:0]   app_accum_b30,
	input  wire logic                             line_cycle_done,
	input  wire logic [eeim_pkg::NUM_PHASE-1:0]   act_tot_sign,
	input  wire logic [eeim_pkg::NUM_PHASE-1:0]   act_fund_sign,
	input  wire logic [eeim_pkg::NUM_REA_PHASE-1:0] rea_tot_sign,
	input  wire logic [eeim_pkg::NUM_REA_PHASE-1:0] rea_fund_sign,
	input  wire logic                             pulse_out1_sum_sign
);
	import eeim_pkg::*;

	logic [NUM_EVT-1:0] en_low_r;
	logic [NUM_EVT-1:0] status_r;
	logic [NUM_EVT-1:0] status_nxt;
	logic [1:0]         mode_r;
	logic [DATA_W-1:0]  rdata_r;
	logic               irq_r;
	logic [SRC_W-1:0]   src;
	logic [SRC_W-1:0]   chg;
	logic [NUM_EVT-1:0] evt;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
		hit = (a == t);
	endfunction

	assign src = {pulse_out1_sum_sign, rea_fund_sign, rea_tot_sign, act_fund_sign,
		act_tot_sign, app_accum_b30, fund_rea_accum_b30, tot_rea_accum_b30,
		fund_act_accum_b30, tot_act_accum_b30};

	eeim_change #(
		.W(SRC_W)
	) u_change (
		.clk (clk),
		.nrst(nrst),
		.din (src),
		.chg (chg)
	);

	assign evt[EVT_TOT_ACT_HF] = |chg[SRC_TOT_ACT +: NUM_PHASE]; // RULE_01
	assign evt[EVT_FUND_ACT_HF] = |chg[SRC_FUND_ACT +: NUM_PHASE]; // RULE_02
	assign evt[EVT_TOT_REA_HF] = |chg[SRC_TOT_REA +: NUM_PHASE]; // RULE_03
	assign evt[EVT_FUND_REA_HF] = |chg[SRC_FUND_REA +: NUM_PHASE]; // RULE_04
	assign evt[EVT_APP_HF] = |chg[SRC_APP +: NUM_PHASE]; // RULE_05
	assign evt[EVT_LINE_DONE] = line_cycle_done; // RULE_06
	assign evt[EVT_SUM1_SIGN] = chg[SRC_SUM1_SIGN]; // RULE_08

	// both sources are watched all the time and only the pulse is selected,
	// so flipping a select bit never fakes a sign change
	generate
		for (genvar i = 0; i < NUM_PHASE; i++) begin : g_act
			assign evt[EVT_ACT_SIGN_A+i] = mode_r[MODE_ACT_SEL_BIT] ?
				chg[SRC_ACT_FUND_SIGN+i] : chg[SRC_ACT_TOT_SIGN+i]; // RULE_07
		end
		for (genvar i = 0; i < NUM_REA_PHASE; i++) begin : g_rea
			assign evt[EVT_REA_SIGN_A+i] = mode_r[MODE_REA_SEL_BIT] ?
				chg[SRC_REA_FUND_SIGN+i] : chg[SRC_REA_TOT_SIGN+i]; // RULE_09
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			en_low_r <= EN_LOW_RST;
		end else if (wr_en && hit(addr, EN_LOW_ADDR)) begin
			en_low_r <= wdata[NUM_EVT-1:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_r <= MODE_RST;
		end else if (wr_en && hit(addr, MODE_ADDR)) begin
			mode_r <= wdata[1:0];
		end
	end

	// read clears; an event in the clearing cycle survives
	always_comb begin
		status_nxt = status_r;
		if (rd_en && hit(addr, STATUS_ADDR)) begin
			status_nxt = STATUS_RST;
		end
		status_nxt = status_nxt | evt; // RULE_10
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_r <= STATUS_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	// registered output costs one cycle of latency after the flag is set
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(status_r & en_low_r); // RULE_10
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= RDATA_IDLE;
		end else begin
			rdata_r <= RDATA_IDLE;
			if (rd_en) begin
				if (hit(addr, EN_LOW_ADDR)) begin
					rdata_r[NUM_EVT-1:0] <= en_low_r;
				end else if (hit(addr, STATUS_ADDR)) begin
					rdata_r[NUM_EVT-1:0] <= status_r;
				end else if (hit(addr, MODE_ADDR)) begin
					rdata_r[1:0] <= mode_r;
				end
			end
		end
	end

	assign rdata = rdata_r;
	assign irq = irq_r;

endmodule

// ===== dv/eeim_top_assertions.sv
// checker for eeim_top: enabled accumulator, line-cycle, sum sign and phase A total active sign events must raise irq two edges later.
// assumes all ports sampled on clk; enable and select shadowed from writes.
`timescale 1ns/1ns
module eeim_checker
	import eeim_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  nrst,
	input wire logic [ADDR_W-1:0]     addr,
	input wire logic [DATA_W-1:0]     wdata,
	input wire logic                  wr_en,
	input wire logic                  irq,
	input wire logic [NUM_PHASE-1:0]  tot_act_accum_b30,
	input wire logic [NUM_PHASE-1:0]  fund_act_accum_b30,
	input wire logic [NUM_PHASE-1:0]  tot_rea_accum_b30,
	input wire logic [NUM_PHASE-1:0]  fund_rea_accum_b30,
	input wire logic [NUM_PHASE-1:0]  app_accum_b30,
	input wire logic                  line_cycle_done,
	input wire logic [NUM_PHASE-1:0]  act_tot_sign,
	input wire logic                  pulse_out1_sum_sign
);
	logic [11:0] en_r;
	logic        mode_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			en_r <= 12'h000;
			mode_r <= 1'b0;
		end else if (wr_en) begin
			if (addr == EN_LOW_ADDR) en_r <= wdata[11:0];
			if (addr == MODE_ADDR) mode_r <= wdata[0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// one edge to set status, one more for the registered irq
	sequence s_raise;
		##2 irq;
	endsequence
	AST_TOT_ACT: assert property ($changed(tot_act_accum_b30) && en_r[0] |-> s_raise)
		else $error("no irq after total active toggle");
	AST_FUND_ACT: assert property ($changed(fund_act_accum_b30) && en_r[1] |-> s_raise)
		else $error("no irq after fund active toggle");
	AST_TOT_REA: assert property ($changed(tot_rea_accum_b30) && en_r[2] |-> s_raise)
		else $error("no irq after total reactive toggle");
	AST_FUND_REA: assert property ($changed(fund_rea_accum_b30) && en_r[3] |-> s_raise)
		else $error("no irq after fund reactive toggle");
	AST_APP: assert property ($changed(app_accum_b30) && en_r[4] |-> s_raise)
		else $error("no irq after apparent toggle");
	AST_LINE: assert property (line_cycle_done && en_r[5] |-> s_raise)
		else $error("no irq after line cycle end");
	AST_ACT_A: assert property (!mode_r && $changed(act_tot_sign[0]) && en_r[6] |-> s_raise)
		else $error("no irq after phase a sign change");
	AST_SUM1: assert property ($changed(pulse_out1_sum_sign) && en_r[9] |-> s_raise)
		else $error("no irq after sum sign change");
	AST_MASKED: assert property (en_r == 12'h000 |=> !irq)
		else $error("irq with all enables clear");
endmodule

bind eeim_top eeim_checker i_chk (.clk, .nrst, .addr, .wdata, .wr_en, .irq,
	.tot_act_accum_b30, .fund_act_accum_b30, .tot_rea_accum_b30, .fund_rea_accum_b30,
	.app_accum_b30, .line_cycle_done, .act_tot_sign, .pulse_out1_sum_sign);

// ===== dv/energy_event_interrupt_mask_test.sv
// testbench for eeim_top: register tasks and one toggle per event source in each of the two select modes.
// assumes read data appear only in the cycle after the strobe.
`timescale 1ns/1ns
module energy_event_interrupt_mask_test;
	import eeim_pkg::*;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [31:0] wdata = 32'h0;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [31:0] rdata;
	logic        irq;
	logic [26:0] src = 27'h0;
	int          num_errors = 0;
	int          compares = 0;
	always #5 clk = ~clk;
	eeim_top i_dut (.clk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq,
		.tot_act_accum_b30(src[2:0]), .fund_act_accum_b30(src[5:3]),
		.tot_rea_accum_b30(src[8:6]), .fund_rea_accum_b30(src[11:9]),
		.app_accum_b30(src[14:12]), .act_tot_sign(src[17:15]), .act_fund_sign(src[20:18]),
		.rea_tot_sign(src[22:21]), .rea_fund_sign(src[24:23]),
		.pulse_out1_sum_sign(src[25]), .line_cycle_done(src[26]));
	// status bit expected from source j; unselected sign sources give none
	function logic [31:0] eb(input int j, input logic m);
		if (j < 15) return 32'h1 << (j / 3);
		if (j < 18) return m ? 32'h0 : 32'h1 << (j - 9);
		if (j < 21) return m ? 32'h1 << (j - 12) : 32'h0;
		if (j < 23) return m ? 32'h0 : 32'h1 << (j - 11);
		if (j < 25) return m ? 32'h1 << (j - 13) : 32'h0;
		if (j < 26) return 32'h200;
		return 32'h20;
	endfunction
	task chk(input logic [31:0] a, input logic [31:0] e);
		compares++;
		if (a !== e) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, a, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk) wr_en <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [15:0] a, input logic [31:0] e);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk) rd_en <= 1'b0;
		#1 chk(rdata, e);
		// read data must fall back to zero after its single cycle
		@(posedge clk) #1 chk(rdata, 32'h0);
	endtask
	task final_report;
		if (num_errors == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		final_report;
	end
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rd(EN_LOW_ADDR, 32'h0);
		rd(16'h0000, 32'h0);
		src[0] <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({31'h0, irq}, 32'h0);
		@(posedge clk);
		wr(EN_LOW_ADDR, 32'hFFFFFFFF);
		#1 chk({31'h0, irq}, 32'h1);
		@(posedge clk);
		rd(STATUS_ADDR, 32'h1);
		rd(STATUS_ADDR, 32'h0);
		rd(EN_LOW_ADDR, 32'hFFF);
		wr(STATUS_ADDR, 32'hFFFFFFFF);
		rd(STATUS_ADDR, 32'h0);
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			wr(MODE_ADDR, {30'h0, m[0], m[0]});
			for (int j = 0; j < 27; j++) begin
				@(posedge clk) src[j] <= ~src[j];
				@(posedge clk) if (j == 26) src[j] <= 1'b0;
				@(posedge clk) #1 chk({31'h0, irq}, {31'h0, eb(j, m[0]) != 32'h0});
				@(posedge clk);
				rd(STATUS_ADDR, eb(j, m[0]));
				@(posedge clk) #1 chk({31'h0, irq}, 32'h0);
			end
		end
		final_report;
	end
endmodule
